// [rtl/ebda_top.sv]
// Operation
// - Areas 2 to 4 are wholly external.
// - Area 5 external except RAM, prohibited.
// - On-chip RAM answers only when enabled.
// - Areas 6, 7 external except I/O region.
// - Lanes follow width, size and endian.
// - Eight-bit areas: one byte, lower lane.
// - Eight-bit areas: word 2, longword 4 cycles.
// - Eight-bit big endian: high byte first.
// - Eight-bit little endian: low byte first.
// - Sixteen-bit areas: byte or word per cycle.
// - Big endian: even upper, odd lower lane.
// - Little endian: even lower, odd upper lane.
// - Even word one cycle, odd word two.
// - Big endian longword: two or three cycles.
// - Little endian cycles start with low bytes.
// - Lane write strobes mark valid write lanes.
// - Each area selectable 8 or 16 bits.
// - Areas 7..2 endian selectable, default big.
//
// Local design decisions: the register offsets and the Avalon-MM interface to the registers.
`include "ebda_cfg.svh"

module ebda_top #(
  parameter logic [7:0] BW_RESET = `EBDA_BWIDTH_RST
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic req_valid,
  output logic req_ready,
  input wire ebda_pkg::ebda_req_t req,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output ebda_pkg::ebda_rsp_t rsp,
  output logic ext_valid,
  output ebda_pkg::ebda_ext_t ext_cyc,
  input wire logic ext_done,
  input wire logic [15:0] ext_rdata
);

  //////////////////////////////////////////////////////////////////////////

  // Plan of one external cycle, kept beside the outputs it produces.
  typedef struct packed {
    logic [23:0] addr;
    logic upper;
    logic lower;
    logic [1:0] upos;
    logic [1:0] lpos;
    logic [2:0] nbytes;
    logic [15:0] wdata;
  } ebda_cyc_t;

  typedef struct packed {
    logic bus_wait;
    logic [31:0] bus_rdata;
    logic ram_en;
    logic ext_mode;
    logic [7:0] bwidth;
    logic [7:0] endian;
    ebda_pkg::ebda_state_t fsm;
    logic [23:0] base;
    logic [2:0] idx;
    logic [2:0] nbt;
    logic wide;
    logic le;
    logic wr;
    logic [31:0] wd;
    logic [31:0] acc;
    ebda_cyc_t cyc;
    logic ext_vld;
    logic rsp_vld;
    ebda_pkg::ebda_rsp_t rsp;
    logic [2:0] ncyc;
    logic ext_sb_up;
    logic ext_sb_lo;
  } ebda_st_t;

  ebda_st_t s_r;
  ebda_st_t s_nxt;
  logic buf_vld;
  logic buf_rdy;
  ebda_pkg::ebda_req_t buf_req;

  //////////////////////////////////////////////////////////////////////////

  // Where an address belongs; areas 0 and 1 are not handled here.
  function automatic ebda_pkg::ebda_cls_t classify(
    input logic [23:0] a,
    input logic ram_en,
    input logic extm
  );
    logic [2:0] area;
    area = a[23:21];
    classify = ebda_pkg::EBDA_CLS_EXT;
    if (!extm || area < `EBDA_AREA_FIRST_EXT) begin
      classify = ebda_pkg::EBDA_CLS_OTHER;
    end else if (area == `EBDA_AREA_RAM) begin
      if (ram_en && a >= `EBDA_RAM_BASE && a <= `EBDA_RAM_LIMIT) begin
        classify = ebda_pkg::EBDA_CLS_RAM;
      end else if (a >= `EBDA_PROH_BASE && a <= `EBDA_PROH_LIMIT) begin
        classify = ebda_pkg::EBDA_CLS_PROH;
      end
    end else if (area == `EBDA_AREA_IO6) begin
      if (a >= `EBDA_IO6_BASE && a <= `EBDA_IO6_LIMIT) begin
        classify = ebda_pkg::EBDA_CLS_IO;
      end
    end else if (area == `EBDA_AREA_IO7) begin
      if (a >= `EBDA_IO7_BASE && a <= `EBDA_IO7_LIMIT) begin
        classify = ebda_pkg::EBDA_CLS_IO;
      end
    end
    // Areas two to four fall through as external.
  endfunction

  // Value byte that lives at memory offset mi of the transfer.
  function automatic logic [1:0] byte_pos(
    input logic [2:0] mi,
    input logic [2:0] nbt,
    input logic le
  );
    logic [2:0] p;
    p = le ? mi : 3'(nbt - 3'h1 - mi);
    byte_pos = p[1:0];
  endfunction

  // Works out the next external cycle from the byte offset reached so far.
  function automatic ebda_cyc_t plan_cycle(
    input logic [23:0] base,
    input logic [2:0] idx,
    input logic [2:0] nbt,
    input logic wide,
    input logic le,
    input logic [31:0] wd
  );
    ebda_cyc_t c;
    logic [2:0] rem;
    logic two;
    logic a0;
    logic up;
    logic [1:0] pos;
    logic [2:0] mi;
    c = '0;
    c.addr = 24'(base + {21'h0, idx});
    rem = 3'(nbt - idx);
    two = wide & ~c.addr[0] & (rem >= 3'h2);
    c.nbytes = two ? 3'h2 : 3'h1;
    for (int j = 0; j < 2; j++) begin
      if (j == 0 || two) begin
        mi = 3'(idx + 3'(j));
        a0 = (j == 1) ? 1'b1 : c.addr[0];
        up = wide & ~(a0 ^ le);
        pos = byte_pos(mi, nbt, le);
        if (up) begin
          c.upper = 1'b1;
          c.upos = pos;
          c.wdata[15:8] = wd[{pos, 3'b000} +: 8];
        end else begin
          c.lower = 1'b1;
          c.lpos = pos;
          c.wdata[7:0] = wd[{pos, 3'b000} +: 8];
        end
      end
    end
    plan_cycle = c;
  endfunction

  //////////////////////////////////////////////////////////////////////////

  // Two-entry buffer decouples the masters from external cycle stalls.
  ebda_buf #(
    .W($bits(ebda_pkg::ebda_req_t)),
    .DEPTH(2)
  ) u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(buf_vld),
    .out_ready(buf_rdy),
    .out_data(buf_req)
  );

  assign buf_rdy = (s_r.fsm == ebda_pkg::EBDA_ST_IDLE);

  // Outputs are plain wires from state flip-flops.
  assign avs_readdata = s_r.bus_rdata;
  assign avs_waitrequest = s_r.bus_wait;
  assign rsp_valid = s_r.rsp_vld;
  assign rsp = s_r.rsp;
  assign ext_valid = s_r.ext_vld;
  assign ext_cyc.addr = s_r.cyc.addr;
  assign ext_cyc.write = s_r.wr;
  assign ext_cyc.upper = s_r.cyc.upper;
  assign ext_cyc.lower = s_r.cyc.lower;
  assign ext_cyc.upper_lane_write_strobe = s_r.ext_sb_up;
  assign ext_cyc.lower_lane_write_strobe = s_r.ext_sb_lo;
  assign ext_cyc.wdata = s_r.cyc.wdata;

  //////////////////////////////////////////////////////////////////////////

  // Next state: register slave, then the transfer engine.
  always_comb begin
    ebda_pkg::ebda_cls_t cls;
    logic [2:0] nb;
    logic [2:0] nidx;
    ebda_cyc_t nc;
    logic [31:0] rd;
    cls = ebda_pkg::EBDA_CLS_OTHER;
    nb = 3'h1;
    nidx = 3'h0;
    nc = '0;
    rd = 32'h0;
    s_nxt = s_r;

    // Read data is latched in the cycle that drops waitrequest, so it
    // stands at the edge where the master takes it.
    case (avs_address)
      `EBDA_OFF_SYSCTL: begin
        rd[`EBDA_SYS_ONCHIP_RAM_ENABLE_BIT] = s_r.ram_en;
        rd[`EBDA_SYS_EXTM_BIT] = s_r.ext_mode;
      end
      `EBDA_OFF_BWIDTH: rd[7:0] = s_r.bwidth;
      `EBDA_OFF_ENDIAN: rd[7:0] = s_r.endian;
      `EBDA_OFF_STATUS: begin
        rd[0] = (s_r.fsm != ebda_pkg::EBDA_ST_IDLE);
        rd[6:4] = s_r.ncyc;
      end
      default: rd = 32'h0;
    endcase
    if ((avs_read || avs_write) && s_r.bus_wait) begin
      s_nxt.bus_wait = 1'b0;
      s_nxt.bus_rdata = avs_read ? rd : 32'h0;
    end else if (!s_r.bus_wait) begin
      s_nxt.bus_wait = 1'b1;
      // Writes land at the edge where the master sees waitrequest low.
      if (avs_write && avs_byteenable[0]) begin
        case (avs_address)
          `EBDA_OFF_SYSCTL: begin
            s_nxt.ram_en = avs_writedata[`EBDA_SYS_ONCHIP_RAM_ENABLE_BIT];
            s_nxt.ext_mode = avs_writedata[`EBDA_SYS_EXTM_BIT];
          end
          `EBDA_OFF_BWIDTH: s_nxt.bwidth = avs_writedata[7:0];
          `EBDA_OFF_ENDIAN: s_nxt.endian = avs_writedata[7:0] & `EBDA_LE_MASK;
          default: s_nxt.bus_wait = 1'b1;
        endcase
      end
    end

    // A transfer is owned until its response is taken; nothing else is
    // popped meanwhile, which keeps split cycles contiguous.
    case (s_r.fsm)
      ebda_pkg::EBDA_ST_IDLE: begin
        if (buf_vld) begin
          cls = classify(buf_req.addr, s_r.ram_en, s_r.ext_mode);
          case (buf_req.size)
            ebda_pkg::EBDA_SZ_BYTE: nb = 3'h1;
            ebda_pkg::EBDA_SZ_WORD: nb = 3'h2;
            default: nb = 3'h4;
          endcase
          s_nxt.base = buf_req.addr;
          s_nxt.nbt = nb;
          s_nxt.idx = 3'h0;
          s_nxt.wr = buf_req.write;
          s_nxt.wd = buf_req.wdata;
          s_nxt.acc = 32'h0;
          s_nxt.wide = s_r.bwidth[buf_req.addr[23:21]];
          s_nxt.le = s_r.endian[buf_req.addr[23:21]];
          if (cls == ebda_pkg::EBDA_CLS_EXT) begin
            nc = plan_cycle(buf_req.addr, 3'h0, nb, s_nxt.wide,
                            s_nxt.le, buf_req.wdata);
            s_nxt.cyc = nc;
            s_nxt.ext_sb_up = buf_req.write & nc.upper;
            s_nxt.ext_sb_lo = buf_req.write & nc.lower;
            s_nxt.ext_vld = 1'b1;
            s_nxt.ncyc = 3'h1;
            s_nxt.fsm = ebda_pkg::EBDA_ST_EXT;
          end else begin
            // Internal targets get no external cycle at all.
            s_nxt.rsp = '{rdata: 32'h0, cls: cls, cycles: 3'h0};
            s_nxt.ncyc = 3'h0;
            s_nxt.rsp_vld = 1'b1;
            s_nxt.fsm = ebda_pkg::EBDA_ST_RESP;
          end
        end
      end
      ebda_pkg::EBDA_ST_EXT: begin
        if (ext_done) begin
          if (!s_r.wr && s_r.cyc.upper) begin
            s_nxt.acc[{s_r.cyc.upos, 3'b000} +: 8] = ext_rdata[15:8];
          end
          if (!s_r.wr && s_r.cyc.lower) begin
            s_nxt.acc[{s_r.cyc.lpos, 3'b000} +: 8] = ext_rdata[7:0];
          end
          nidx = 3'(s_r.idx + s_r.cyc.nbytes);
          s_nxt.idx = nidx;
          if (nidx == s_r.nbt) begin
            s_nxt.ext_vld = 1'b0;
            s_nxt.ext_sb_up = 1'b0;
            s_nxt.ext_sb_lo = 1'b0;
            s_nxt.rsp = '{rdata: s_nxt.acc, cls: ebda_pkg::EBDA_CLS_EXT,
                          cycles: s_r.ncyc};
            s_nxt.rsp_vld = 1'b1;
            s_nxt.fsm = ebda_pkg::EBDA_ST_RESP;
          end else begin
            nc = plan_cycle(s_r.base, nidx, s_r.nbt, s_r.wide, s_r.le, s_r.wd);
            s_nxt.cyc = nc;
            s_nxt.ext_sb_up = s_r.wr & nc.upper;
            s_nxt.ext_sb_lo = s_r.wr & nc.lower;
            s_nxt.ncyc = 3'(s_r.ncyc + 3'h1);
          end
        end
      end
      ebda_pkg::EBDA_ST_RESP: begin
        if (rsp_ready) begin
          s_nxt.rsp_vld = 1'b0;
          s_nxt.fsm = ebda_pkg::EBDA_ST_IDLE;
        end
      end
      default: s_nxt.fsm = ebda_pkg::EBDA_ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////

  // State register; control settings take their documented defaults.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.bus_wait <= 1'b1;
      s_r.ram_en <= 1'(`EBDA_SYSCTL_RST >> `EBDA_SYS_ONCHIP_RAM_ENABLE_BIT);
      s_r.ext_mode <= 1'(`EBDA_SYSCTL_RST >> `EBDA_SYS_EXTM_BIT);
      s_r.bwidth <= BW_RESET;
      s_r.endian <= `EBDA_ENDIAN_RST;
      s_r.fsm <= ebda_pkg::EBDA_ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // ebda_top

// [shared/ebda_cfg.svh]
`ifndef EBDA_CFG_SVH
`define EBDA_CFG_SVH

// Register byte offsets on the control bus.
`define EBDA_OFF_SYSCTL 4'h0
`define EBDA_OFF_BWIDTH 4'h4
`define EBDA_OFF_ENDIAN 4'h8
`define EBDA_OFF_STATUS 4'hC

// Field positions in the system control register.
`define EBDA_SYS_ONCHIP_RAM_ENABLE_BIT 0
`define EBDA_SYS_EXTM_BIT 1

// Reset values.
`define EBDA_SYSCTL_RST 2'h3
`define EBDA_BWIDTH_RST 8'hFF
`define EBDA_ENDIAN_RST 8'h00
`define EBDA_LE_MASK 8'hFC

// Area numbering and special regions.
`define EBDA_AREA_FIRST_EXT 3'h2
`define EBDA_AREA_RAM 3'h5
`define EBDA_AREA_IO6 3'h6
`define EBDA_AREA_IO7 3'h7
`define EBDA_RAM_BASE 24'hBF0000
`define EBDA_RAM_LIMIT 24'hBF7FFF
`define EBDA_PROH_BASE 24'hBF8000
`define EBDA_PROH_LIMIT 24'hBFFFFF
`define EBDA_IO6_BASE 24'hDFF000
`define EBDA_IO6_LIMIT 24'hDFFFFF
`define EBDA_IO7_BASE 24'hFFF000
`define EBDA_IO7_LIMIT 24'hFFFFFF

`endif

// [shared/ebda_pkg.sv]
package ebda_pkg;

  // Transfer size requested by an internal master.
  typedef enum logic [1:0] {
    EBDA_SZ_BYTE = 2'h0,
    EBDA_SZ_WORD = 2'h1,
    EBDA_SZ_LONG = 2'h2
  } ebda_size_t;

  // Where an address lands.
  typedef enum logic [2:0] {
    EBDA_CLS_EXT = 3'h0,
    EBDA_CLS_RAM = 3'h1,
    EBDA_CLS_IO = 3'h2,
    EBDA_CLS_PROH = 3'h3,
    EBDA_CLS_OTHER = 3'h4
  } ebda_cls_t;

  typedef enum logic [1:0] {
    EBDA_ST_IDLE = 2'b00,
    EBDA_ST_EXT = 2'b01,
    EBDA_ST_RESP = 2'b10
  } ebda_state_t;

  typedef struct packed {
    logic [23:0] addr;
    ebda_size_t size;
    logic write;
    logic [31:0] wdata;
  } ebda_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    ebda_cls_t cls;
    logic [2:0] cycles;
  } ebda_rsp_t;

  // One external bus cycle as handed to the cycle timing logic.
  typedef struct packed {
    logic [23:0] addr;
    logic write;
    logic upper;
    logic lower;
    logic upper_lane_write_strobe;
    logic lower_lane_write_strobe;
    logic [15:0] wdata;
  } ebda_ext_t;

endpackage

// [rtl/ebda_buf.sv]
// Small FIFO held in flip-flops; in_ready is registered so the source sees
// back-pressure without a combinational path from the drain side.
module ebda_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic in_rdy;
  } ebda_buf_st_t;

  ebda_buf_st_t s_r;
  ebda_buf_st_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = s_r.in_rdy;
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];

  // Push and pop may happen together; the count only moves on one of them.
  always_comb begin
    s_nxt = s_r;
    push = in_valid & s_r.in_rdy;
    pop = out_ready & (s_r.cnt != '0);
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    s_nxt.in_rdy = (s_nxt.cnt != FULL);
  end

  // State register.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.in_rdy <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // ebda_buf

// [bench/ebda_assertions.sv]
module ebda_assertions (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire ebda_pkg::ebda_rsp_t rsp,
  input wire logic ext_valid,
  input wire ebda_pkg::ebda_ext_t ext_cyc,
  input wire logic ext_done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // Strobes are the write flag gated by the lane in use.
  a_lane_strobe: assert property (
    ext_valid |-> ext_cyc.upper_lane_write_strobe == (ext_cyc.write && ext_cyc.upper)
      && ext_cyc.lower_lane_write_strobe == (ext_cyc.write && ext_cyc.lower))
    else $error("lane strobe does not follow write and lane");
  a_lane_used: assert property (
    ext_valid |-> ext_cyc.upper || ext_cyc.lower)
    else $error("external cycle without a lane");
  a_word_even: assert property (
    ext_valid && ext_cyc.upper && ext_cyc.lower |-> !ext_cyc.addr[0])
    else $error("word cycle at odd address");
  // A presented cycle may not change before the timing logic finishes it.
  a_cycle_hold: assert property (
    ext_valid && !ext_done |=> ext_valid && $stable(ext_cyc))
    else $error("external cycle changed before done");
  a_addr_step: assert property (
    ext_valid && ext_done |=> !ext_valid || ext_cyc.addr == $past(ext_cyc.addr)
      + (($past(ext_cyc.upper) && $past(ext_cyc.lower)) ? 24'h000002 : 24'h000001))
    else $error("split cycle address not ascending");
  a_fall_rsp: assert property (
    $fell(ext_valid) |-> rsp_valid)
    else $error("no response after last external cycle");
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered in one cycle");
  a_rsp_hold: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("response dropped while stalled");
  a_internal_none: assert property (
    rsp_valid && rsp.cls != ebda_pkg::EBDA_CLS_EXT |-> rsp.cycles == 3'h0)
    else $error("internal access used external cycles");
  a_ext_count: assert property (
    rsp_valid && rsp.cls == ebda_pkg::EBDA_CLS_EXT |-> rsp.cycles inside {[3'h1:3'h4]})
    else $error("external cycle count out of range");
endmodule // ebda_assertions

bind ebda_top ebda_assertions u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .ext_valid(ext_valid),
  .ext_cyc(ext_cyc), .ext_done(ext_done));

// [bench/ebda_ext_model.sv]
module ebda_ext_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ext_valid,
  input wire ebda_pkg::ebda_ext_t ext_cyc,
  input wire logic [7:0] bw,
  input wire logic [7:0] le,
  output logic ext_done,
  output logic [15:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int wt;
  logic [23:0] e;
  logic [2:0] ar;
  // Contents follow from the address, so no storage is needed.
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'hA5;
  endfunction
  // Answers after 0 to 3 waits; idle data flips so stale lanes never match.
  always @(posedge ref_clk or posedge sys_rst) begin
    e = {ext_cyc.addr[23:1], 1'b0};
    ar = ext_cyc.addr[23:21];
    if (sys_rst) begin
      ext_done <= 1'b0;
      ext_rdata <= 16'h0000;
      wt <= 0;
    end else if (ext_valid && !ext_done && wt == 0) begin
      ext_done <= 1'b1;
      wt <= $urandom % 4;
      if (!bw[ar]) ext_rdata <= {~mem(ext_cyc.addr), mem(ext_cyc.addr)};
      else if (le[ar]) ext_rdata <= {mem(e | 24'h1), mem(e)};
      else ext_rdata <= {mem(e), mem(e | 24'h1)};
    end else begin
      ext_done <= 1'b0;
      ext_rdata <= ~ext_rdata;
      if (ext_valid && !ext_done) wt <= wt - 1;
    end
  end
endmodule // ebda_ext_model

// [bench/testbench.sv]
`include "ebda_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [23:0] a; logic u; logic l; logic w; logic [15:0] d;} ebda_tb_cyc_t;
  logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, req_valid, req_ready;
  logic rsp_valid, rsp_ready, ext_valid, ext_done, onchip_ram_enable, extm;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd, mm;
  logic [15:0] ext_rdata, m;
  logic [7:0] bw, le;
  logic [2:0] lc;
  ebda_pkg::ebda_req_t req;
  ebda_pkg::ebda_rsp_t rsp, mr;
  ebda_pkg::ebda_ext_t ext_cyc;
  ebda_tb_cyc_t cq[$];
  ebda_tb_cyc_t mc;
  ebda_pkg::ebda_rsp_t rq[$];
  logic [31:0] mq[$];
  logic [23:0] tbl[7] = '{24'hBF0000, 24'hBF8000, 24'hDFF000, 24'hFFF000, 24'h000010,
    24'h200010, 24'h400010};
  int failures, cmp_count, k, s, o, w, ar;
  ebda_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
    .ext_valid(ext_valid), .ext_cyc(ext_cyc), .ext_done(ext_done), .ext_rdata(ext_rdata));
  ebda_ext_model u_mem (.ref_clk(ref_clk), .sys_rst(sys_rst), .ext_valid(ext_valid),
    .ext_cyc(ext_cyc), .bw(bw), .le(le), .ext_done(ext_done), .ext_rdata(ext_rdata));
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ 8'hA5;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Holds the request until waitrequest is seen low at an edge.
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= ad;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) failures++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    req_valid <= 1'b0;
    while ((cq.size() != 0 || rq.size() != 0) && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) failures++;
  endtask
  task automatic cfg(input logic [7:0] bwv, input logic [7:0] lev);
    drain();
    // Idle after the drain, with the cycle count of the last transfer kept.
    bus(1'b0, `EBDA_OFF_STATUS, 32'h0, rd);
    chk("status", rd, {25'h0, lc, 4'h0});
    bus(1'b1, `EBDA_OFF_BWIDTH, {24'h0, bwv}, rd);
    bus(1'b1, `EBDA_OFF_ENDIAN, {24'h0, lev}, rd);
    bus(1'b0, `EBDA_OFF_BWIDTH, 32'h0, rd);
    chk("bwidth", rd, {24'h0, bwv});
    bus(1'b0, `EBDA_OFF_ENDIAN, 32'h0, rd);
    chk("endian", rd, {24'h0, lev & `EBDA_LE_MASK});
    bw = bwv;
    le = lev & `EBDA_LE_MASK;
  endtask
  // Works out class, split cycles and read value, then offers the request.
  task automatic put(input logic [23:0] a, input int sz, input logic wr,
    input logic [31:0] wd);
    int n, i, nc;
    logic [2:0] an;
    logic [7:0] b[4];
    ebda_tb_cyc_t c;
    ebda_pkg::ebda_rsp_t r;
    n = 1 << sz;
    an = a[23:21];
    r = '0;
    nc = 0;
    for (i = 0; i < n; i++) begin
      b[i] = le[an] ? wd[8*i+:8] : wd[8*(n-1-i)+:8];
      r.rdata = le[an] ? r.rdata | (32'(mem(a + 24'(i))) << 8*i)
        : (r.rdata << 8) | 32'(mem(a + 24'(i)));
    end
    if (!extm || an < 3'h2) r.cls = ebda_pkg::EBDA_CLS_OTHER;
    else if (onchip_ram_enable && a >= `EBDA_RAM_BASE && a <= `EBDA_RAM_LIMIT) r.cls = ebda_pkg::EBDA_CLS_RAM;
    else if (a >= `EBDA_PROH_BASE && a <= `EBDA_PROH_LIMIT) r.cls = ebda_pkg::EBDA_CLS_PROH;
    else if ((a >= `EBDA_IO6_BASE && a <= `EBDA_IO6_LIMIT) || a >= `EBDA_IO7_BASE)
      r.cls = ebda_pkg::EBDA_CLS_IO;
    else r.cls = ebda_pkg::EBDA_CLS_EXT;
    i = 0;
    while (r.cls == ebda_pkg::EBDA_CLS_EXT && i < n) begin
      c.a = a + 24'(i);
      c.w = wr;
      if (bw[an] && !c.a[0] && n - i >= 2) begin
        c.u = 1'b1;
        c.l = 1'b1;
        c.d = le[an] ? {b[i+1], b[i]} : {b[i], b[i+1]};
        i += 2;
      end else begin
        c.l = !bw[an] || (c.a[0] ^ le[an]);
        c.u = !c.l;
        c.d = {b[i], b[i]};
        i++;
      end
      cq.push_back(c);
      nc++;
    end
    r.cycles = 3'(nc);
    lc = r.cycles;
    rq.push_back(r);
    mq.push_back((wr || r.cls != ebda_pkg::EBDA_CLS_EXT) ? 32'h0 : 32'hFFFFFFFF >> (32 - 8*n));
    req_valid <= 1'b1;
    req <= '{addr: a, size: ebda_pkg::ebda_size_t'(sz[1:0]), write: wr, wdata: wd};
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 3000);
    if (i >= 3000) failures++;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Each finished external cycle is held against the reckoned list.
  always @(posedge ref_clk) begin
    if (!sys_rst && ext_valid && ext_done) begin
      mc = cq.size() ? cq.pop_front() : '{default: 0};
      m = {{8{mc.u}}, {8{mc.l}}};
      chk("ext addr", 32'(ext_cyc.addr), 32'(mc.a));
      chk("ext lanes", {ext_cyc.upper, ext_cyc.lower}, {mc.u, mc.l});
      chk("ext strobes", {ext_cyc.upper_lane_write_strobe, ext_cyc.lower_lane_write_strobe},
        {mc.u & mc.w, mc.l & mc.w});
      if (mc.w) chk("ext data", ext_cyc.wdata & m, mc.d & m);
    end
    if (!sys_rst && rsp_valid && rsp_ready) begin
      mr = rq.size() ? rq.pop_front() : '0;
      mm = mq.size() ? mq.pop_front() : 32'h0;
      chk("rsp class", 32'(rsp.cls), 32'(mr.cls));
      chk("rsp cycles", 32'(rsp.cycles), 32'(mr.cycles));
      chk("rsp rdata", rsp.rdata & mm, mr.rdata & mm);
    end
  end
  // The receiver stalls at random so the two-entry buffer fills up.
  always @(posedge ref_clk) rsp_ready <= ($urandom % 4) != 0;
  initial begin
    #500000;
    failures++;
    summarize();
  end
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    {avs_read, avs_write, req_valid, onchip_ram_enable, extm} = 5'h03;
    {avs_address, avs_writedata, req} = '0;
    avs_byteenable = 4'hF;
    rsp_ready = 1'b1;
    bw = 8'hFF;
    lc = 3'h0;
    le = 8'h00;
    failures = 0;
    cmp_count = 0;
    void'($urandom(46));
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset values and an unmapped offset.
    bus(1'b0, `EBDA_OFF_SYSCTL, 32'h0, rd);
    chk("sysctl", rd, 32'h3);
    bus(1'b0, `EBDA_OFF_BWIDTH, 32'h0, rd);
    chk("bwidth reset", rd, 32'hFF);
    bus(1'b0, `EBDA_OFF_ENDIAN, 32'h0, rd);
    chk("endian reset", rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    for (k = 0; k < 6; k++) begin
      cfg(k < 2 ? {8{k[0]}} : 8'($urandom), k == 2 ? 8'hFF : k < 2 ? 8'h00 : 8'($urandom));
      for (ar = 2; ar < 8; ar++)
        for (s = 0; s < 3; s++)
          for (o = 0; o < 2; o++)
            for (w = 0; w < 2; w++)
              put({3'(ar), 21'h000100} + 24'(o), s, w[0], $urandom);
      for (o = 0; o < 16; o++)
        put({3'(2 + $urandom % 6), 21'($urandom % 21'h0FFFFF)}, $urandom % 3, o[0], $urandom);
    end
    for (k = 0; k < 3; k++) begin
      drain();
      onchip_ram_enable = (k != 1);
      extm = (k != 2);
      bus(1'b1, `EBDA_OFF_SYSCTL, {30'h0, extm, onchip_ram_enable}, rd);
      for (o = 0; o < 7; o++)
        put(tbl[o], o % 3, o[0], $urandom);
    end
    drain();
    summarize();
  end
endmodule // testbench
